// File: shared/scmc_defs.svh
// Purpose: Constants of the system clock and mode controller.
// Assumes: One 125 MHz clock; register offsets are byte addresses.
// Notes:   Register byte lanes above bit 7 read as zero.
// Behaviour
// - Clocks via 2-stage prescaler, 21-stage divider.
// - Clear prescaler and divider on reset, stop.
// - Stage 7 input chosen by mode, selects.
// - Slow and sleep feed stage 7 from low clock.
// - Warm-up after stop from normal uses stage 6.
// - Machine cycle is four one-clock states.
// - Instructions take one to ten whole cycles.
// - Single-clock: high oscillator only, four periods.
// - Reset starts in single-clock normal mode.
// - Idle request halts CPU and watchdog only.
// - Any interrupt ends idle to normal, sleep to slow.
// - Idle release services interrupt or continues next.
// - Halt bit enters timebase-only idle state.
// - Timebase falling edge resumes single-clock normal.
// - Timebase idle release ignores timer enable bit.
// - Timebase interrupt needs three enables all one.
// - Timer enabled at entry sets interrupt latch.
// - Dual mode runs both oscillators, picks clock.
// - Dual cycle: four fast or slow periods.
// - Clock select moves CPU between clocks.
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH

`define SCMC_ADDR_CTRL_ONE   8'h00
`define SCMC_ADDR_CTRL_TWO   8'h04
`define SCMC_ADDR_TB_CTRL    8'h08
`define SCMC_ADDR_STATUS     8'h0C
`define SCMC_ADDR_IRQ_CTRL   8'h10

`define SCMC_C1_STOP         7
`define SCMC_C2_IDLE         0
`define SCMC_C2_HALT         1
`define SCMC_C2_SYS_CLOCK_SELECT        2
`define SCMC_C2_LFEN         3
`define SCMC_TB_ST7SEL       0
`define SCMC_TB_SRC_LO       1
`define SCMC_TB_SRC_HI       3
`define SCMC_TB_TEN          4
`define SCMC_IRQ_IME         0
`define SCMC_IRQ_EF          1
`define SCMC_IRQ_LATCH       2
`define SCMC_ST_MODE_HI      3
`define SCMC_ST_MST_LO       4
`define SCMC_ST_MST_HI       5

`define SCMC_PRE_W           2
`define SCMC_LOW_W           6
`define SCMC_HIGH_W          15
`define SCMC_DIV_W           21
`define SCMC_MST_LAST        2'h3
`define SCMC_TB_TAP_BASE     5'h06
`define SCMC_TB_TAP_STEP     5'h02
`define SCMC_WARM_TAP_DEF    20
`define SCMC_RESP_OKAY       2'h0
`define SCMC_RESP_SLVERR     2'h2

`endif

// File: shared/scmc_pkg.sv
// Purpose: Types of the system clock and mode controller.
// Assumes: Constants come from scmc_defs.svh.
// Notes:   Mode codes are numbered from zero in declaration order.
package scmc_pkg;
	typedef enum logic [3:0] {
		single_normal,
		single_idle,
		timebase_only_idle,
		dual_normal,
		dual_idle,
		slow_both_osc,
		sleep_both_osc,
		stop_state,
		warmup
	} scmc_mode_t;
endpackage

// File: core/scmc_cnt.sv
// Purpose: Binary counter segment of the divider chain.
// Assumes: tick is a one-cycle enable.
// Notes:   carry pulses when the segment wraps.
module scmc_cnt #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Count control
	input  wire logic         clr,
	input  wire logic         tick,
	// Count state
	output logic [W-1:0]      q,
	output logic              carry
);
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			q <= '0;
		end else if (tick) begin
			q <= q + 1'b1;
		end
	end

	assign carry = tick & (&q);
endmodule

// File: core/scmc_sync.sv
// Purpose: Two-stage synchroniser for a pin level.
// Assumes: d is asynchronous to aclk.
// Notes:   Only the second stage is visible.
module scmc_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Level
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// File: core/scmc_top.sv
// Purpose: Timing generator and operating-mode control with AXI4-Lite registers.
// Assumes: aclk is the high-frequency basic clock; low clock arrives on a pin.
// Notes:   Stop release pin is active low; interrupts are levels.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "scmc_defs.svh"

module scmc_top
	import scmc_pkg::*;
#(
	parameter int WARM_TAP = `SCMC_WARM_TAP_DEF
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Pins
	input  wire logic        lowfreq_osc_in,
	input  wire logic        stop_release_n,
	input  wire logic        ext_irq,
	// Core side
	input  wire logic        periph_irq,
	output logic             hf_osc_enable,
	output logic             lf_osc_enable,
	output logic             lf_pins_port,
	output logic             cpu_run,
	output logic             wdt_run,
	output logic             periph_run,
	output logic             tbt_run,
	output logic             main_clk_tick,
	output logic [1:0]       machine_state,
	output logic [20:0]      divider_state,
	output logic             irq_take,
	output logic             resume_next,
	output logic             timebase_irq_latch,
	output logic             timebase_irq_take
);
	scmc_mode_t mode_q, mode_d, ret_mode_q;
	logic       lf_s, lf_prev_q, ext_irq_s, stop_rel_n_s;
	logic       stop_req_q, idle_req_q, timing_gen_halt_q, sys_clock_select_q, lf_en_q;
	logic       stage7_source_select_q, timebase_timer_enable_q;
	logic [2:0] timebase_source_select_q;
	logic       irq_master_enable_q, timebase_irq_enable_q, tb_latch_q, tb_armed_q;
	logic       from_normal_q, tb_tap_prev_q;
	logic [1:0] mst_q;
	logic       main_tick_q;
	logic [`SCMC_PRE_W-1:0]  pre_q;
	logic [`SCMC_LOW_W-1:0]  low_q;
	logic [`SCMC_HIGH_W-1:0] high_q;
	logic [`SCMC_DIV_W-1:0]  div;
	logic       pre_c, low_c, high_c, st7_tick, div_clr;
	logic       slow_like, lf_run, hf_run, lf_tick, main_tick, cycle_end, wake;
	logic       take_stop, take_idle, take_halt, tb_fall, tb_tap, idle_exit, tb_exit;
	logic [4:0] tb_idx;
	logic       aw_q, w_q, ar_ok;
	logic [7:0] awaddr_q, wbyte_q;
	logic       wr_go;

	scmc_sync u_sync_lf (.aclk(aclk), .aresetn(aresetn), .d(lowfreq_osc_in), .q(lf_s));
	scmc_sync u_sync_ext (.aclk(aclk), .aresetn(aresetn), .d(ext_irq), .q(ext_irq_s));
	scmc_sync u_sync_stp (.aclk(aclk), .aresetn(aresetn), .d(stop_release_n), .q(stop_rel_n_s));

	assign slow_like = (mode_q == slow_both_osc) || (mode_q == sleep_both_osc);
	assign lf_run    = lf_en_q && (mode_q != stop_state);
	// high oscillator runs except in stop.
	assign hf_run    = (mode_q != stop_state);
	assign lf_tick   = lf_run && lf_s && !lf_prev_q;
	assign main_tick = slow_like ? lf_tick : hf_run;
	assign cycle_end = main_tick && (mst_q == `SCMC_MST_LAST);
	assign wake      = periph_irq || ext_irq_s;

	always_comb begin
		if (slow_like) begin
			// low clock in slow and sleep.
			st7_tick = lf_tick;
		end else if ((mode_q == warmup) && from_normal_q) begin
			st7_tick = low_c;
		end else if (stage7_source_select_q) begin
			st7_tick = lf_tick;
		end else begin
			st7_tick = low_c;
		end
	end

	scmc_cnt #(.W(`SCMC_PRE_W)) u_pre (.aclk(aclk), .aresetn(aresetn), .clr(div_clr),
		.tick(hf_run && !slow_like), .q(pre_q), .carry(pre_c));
	scmc_cnt #(.W(`SCMC_LOW_W)) u_low (.aclk(aclk), .aresetn(aresetn), .clr(div_clr),
		.tick(pre_c), .q(low_q), .carry(low_c));
	scmc_cnt #(.W(`SCMC_HIGH_W)) u_high (.aclk(aclk), .aresetn(aresetn), .clr(div_clr),
		.tick(st7_tick), .q(high_q), .carry(high_c));
	assign div = {high_q, low_q};

	assign tb_idx = 5'(`SCMC_TB_TAP_BASE + `SCMC_TB_TAP_STEP * {2'h0, timebase_source_select_q});
	assign tb_tap = div[tb_idx];
	assign tb_fall = tb_tap_prev_q && !tb_tap;

	// Mode transitions; cycle-aligned requests wait for the end of S3.
	always_comb begin
		mode_d    = mode_q;
		take_stop = 1'b0;
		take_idle = 1'b0;
		take_halt = 1'b0;
		case (mode_q)
			single_normal: begin
				if (cycle_end) begin
					if (stop_req_q) begin
						mode_d    = stop_state;
						take_stop = 1'b1;
					end else if (timing_gen_halt_q) begin
						mode_d    = timebase_only_idle;
						take_halt = 1'b1;
					end else if (idle_req_q) begin
						mode_d    = single_idle;
						take_idle = 1'b1;
					end else if (lf_en_q) begin
						mode_d = dual_normal;
					end
				end
			end
			single_idle: begin
				if (wake) begin
					mode_d = single_normal;
				end
			end
			timebase_only_idle: begin
				if (tb_fall) begin
					mode_d = single_normal;
				end
			end
			dual_normal: begin
				if (cycle_end) begin
					if (stop_req_q) begin
						mode_d    = stop_state;
						take_stop = 1'b1;
					end else if (idle_req_q) begin
						mode_d    = dual_idle;
						take_idle = 1'b1;
					end else if (sys_clock_select_q) begin
						mode_d = slow_both_osc;
					end else if (!lf_en_q) begin
						mode_d = single_normal;
					end
				end
			end
			dual_idle: begin
				if (wake) begin
					mode_d = dual_normal;
				end
			end
			slow_both_osc: begin
				if (cycle_end) begin
					if (stop_req_q) begin
						mode_d    = stop_state;
						take_stop = 1'b1;
					end else if (idle_req_q) begin
						mode_d    = sleep_both_osc;
						take_idle = 1'b1;
					end else if (!sys_clock_select_q) begin
						mode_d = dual_normal;
					end
				end
			end
			sleep_both_osc: begin
				if (wake) begin
					mode_d = slow_both_osc;
				end
			end
			stop_state: begin
				if (!stop_rel_n_s) begin
					mode_d = warmup;
				end
			end
			warmup: begin
				if (div[WARM_TAP]) begin
					mode_d = ret_mode_q;
				end
			end
			default: begin
				mode_d = single_normal;
			end
		endcase
	end

	// clear on stop entry and release.
	assign div_clr = ((mode_q != stop_state) && (mode_d == stop_state))
		|| ((mode_q == stop_state) && (mode_d == warmup));
	assign idle_exit = ((mode_q == single_idle) || (mode_q == dual_idle)
		|| (mode_q == sleep_both_osc)) && wake;
	assign tb_exit = (mode_q == timebase_only_idle) && tb_fall;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q        <= single_normal;
			ret_mode_q    <= single_normal;
			from_normal_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			if (take_stop) begin
				ret_mode_q    <= mode_q;
				from_normal_q <= (mode_q != slow_both_osc);
			end
		end
	end

	// state counter; instructions span whole cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn || div_clr) begin
			mst_q       <= 2'h0;
			main_tick_q <= 1'b0;
		end else begin
			main_tick_q <= main_tick;
			if (main_tick) begin
				mst_q <= mst_q + 2'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lf_prev_q     <= 1'b0;
			tb_tap_prev_q <= 1'b0;
		end else begin
			lf_prev_q     <= lf_s;
			tb_tap_prev_q <= tb_tap;
		end
	end

	// arm at entry, set latch on return; set beats clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tb_armed_q <= 1'b0;
			tb_latch_q <= 1'b0;
		end else begin
			if (take_halt) begin
				tb_armed_q <= timebase_timer_enable_q;
			end
			if (tb_exit && tb_armed_q) begin
				tb_latch_q <= 1'b1;
			end else if (wr_go && (awaddr_q == `SCMC_ADDR_IRQ_CTRL)
					&& wbyte_q[`SCMC_IRQ_LATCH]) begin
				tb_latch_q <= 1'b0;
			end
		end
	end

	// Control registers; request bits self-clear when taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stop_req_q               <= 1'b0;
			idle_req_q               <= 1'b0;
			timing_gen_halt_q        <= 1'b0;
			sys_clock_select_q       <= 1'b0;
			lf_en_q                  <= 1'b0;
			stage7_source_select_q   <= 1'b0;
			timebase_source_select_q <= 3'h0;
			timebase_timer_enable_q  <= 1'b0;
			irq_master_enable_q      <= 1'b0;
			timebase_irq_enable_q    <= 1'b0;
		end else begin
			if (take_stop) begin
				stop_req_q <= 1'b0;
			end
			if (take_idle) begin
				idle_req_q <= 1'b0;
			end
			if (take_halt) begin
				timing_gen_halt_q <= 1'b0;
			end
			if (wr_go) begin
				if (awaddr_q == `SCMC_ADDR_CTRL_ONE) begin
					stop_req_q <= wbyte_q[`SCMC_C1_STOP];
				end else if (awaddr_q == `SCMC_ADDR_CTRL_TWO) begin
					idle_req_q         <= wbyte_q[`SCMC_C2_IDLE];
					timing_gen_halt_q  <= wbyte_q[`SCMC_C2_HALT];
					sys_clock_select_q <= wbyte_q[`SCMC_C2_SYS_CLOCK_SELECT];
					lf_en_q            <= wbyte_q[`SCMC_C2_LFEN];
				end else if (awaddr_q == `SCMC_ADDR_TB_CTRL) begin
					stage7_source_select_q   <= wbyte_q[`SCMC_TB_ST7SEL];
					timebase_source_select_q <= wbyte_q[`SCMC_TB_SRC_HI:`SCMC_TB_SRC_LO];
					timebase_timer_enable_q  <= wbyte_q[`SCMC_TB_TEN];
				end else if (awaddr_q == `SCMC_ADDR_IRQ_CTRL) begin
					irq_master_enable_q   <= wbyte_q[`SCMC_IRQ_IME];
					timebase_irq_enable_q <= wbyte_q[`SCMC_IRQ_EF];
				end
			end
		end
	end

	// oscillator and run outputs follow the next mode; the pin output is the inverse of the low-oscillator enable bit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hf_osc_enable <= 1'b1;
			lf_osc_enable <= 1'b0;
			lf_pins_port  <= 1'b1;
			cpu_run       <= 1'b1;
			wdt_run       <= 1'b1;
			periph_run    <= 1'b1;
			tbt_run       <= 1'b1;
		end else begin
			hf_osc_enable <= (mode_d != stop_state);
			lf_osc_enable <= lf_en_q && (mode_d != stop_state);
			lf_pins_port  <= !lf_en_q;
			cpu_run       <= (mode_d == single_normal) || (mode_d == dual_normal)
				|| (mode_d == slow_both_osc);
			wdt_run       <= (mode_d == single_normal) || (mode_d == dual_normal)
				|| (mode_d == slow_both_osc);
			periph_run    <= (mode_d != timebase_only_idle) && (mode_d != stop_state)
				&& (mode_d != warmup);
			tbt_run       <= (mode_d != stop_state) && (mode_d != warmup);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_take          <= 1'b0;
			resume_next       <= 1'b0;
			timebase_irq_take <= 1'b0;
		end else begin
			irq_take          <= idle_exit && irq_master_enable_q;
			resume_next       <= idle_exit && !irq_master_enable_q;
			timebase_irq_take <= tb_exit && tb_armed_q && irq_master_enable_q
				&& timebase_irq_enable_q && timebase_timer_enable_q;
		end
	end

	assign main_clk_tick      = main_tick_q;
	assign machine_state      = mst_q;
	assign divider_state      = div;
	assign timebase_irq_latch = tb_latch_q;

	// AXI4-Lite slave: address and data taken in either order.
	assign wr_go = aw_q && w_q && !bvalid;
	assign ar_ok = (araddr == `SCMC_ADDR_CTRL_ONE) || (araddr == `SCMC_ADDR_CTRL_TWO)
		|| (araddr == `SCMC_ADDR_TB_CTRL) || (araddr == `SCMC_ADDR_STATUS)
		|| (araddr == `SCMC_ADDR_IRQ_CTRL);
	assign awready = !aw_q;
	assign wready  = !w_q;
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 8'h00;
			wbyte_q  <= 8'h00;
			bvalid   <= 1'b0;
			bresp    <= `SCMC_RESP_OKAY;
		end else begin
			if (awvalid && !aw_q) begin
				aw_q     <= 1'b1;
				awaddr_q <= awaddr;
			end
			if (wvalid && !w_q) begin
				w_q     <= 1'b1;
				wbyte_q <= wstrb[0] ? wdata[7:0] : 8'h00;
			end
			if (wr_go) begin
				aw_q   <= 1'b0;
				w_q    <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= ((awaddr_q == `SCMC_ADDR_STATUS) || (awaddr_q[1:0] != 2'h0)
					|| (awaddr_q > `SCMC_ADDR_IRQ_CTRL)) ? `SCMC_RESP_SLVERR : `SCMC_RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `SCMC_RESP_OKAY;
		end else if (arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rresp  <= ar_ok ? `SCMC_RESP_OKAY : `SCMC_RESP_SLVERR;
			rdata  <= 32'h0000_0000;
			if (araddr == `SCMC_ADDR_CTRL_ONE) begin
				rdata[`SCMC_C1_STOP] <= stop_req_q;
			end else if (araddr == `SCMC_ADDR_CTRL_TWO) begin
				rdata[3:0] <= {lf_en_q, sys_clock_select_q, timing_gen_halt_q, idle_req_q};
			end else if (araddr == `SCMC_ADDR_TB_CTRL) begin
				rdata[4:0] <= {timebase_timer_enable_q, timebase_source_select_q,
					stage7_source_select_q};
			end else if (araddr == `SCMC_ADDR_STATUS) begin
				rdata[`SCMC_ST_MODE_HI:0] <= mode_q;
				rdata[`SCMC_ST_MST_HI:`SCMC_ST_MST_LO] <= mst_q;
			end else if (araddr == `SCMC_ADDR_IRQ_CTRL) begin
				rdata[2:0] <= {tb_latch_q, timebase_irq_enable_q, irq_master_enable_q};
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	sequence s_idle_wake;
		(mode_q == single_idle) && wake;
	endsequence
	sequence s_resumed;
		(mode_q == single_normal) && (irq_take || resume_next);
	endsequence

	property p_stop_clear;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q != stop_state) && (mode_d == stop_state) |=> (divider_state == 21'h000000);
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("divider not cleared");

	property p_slow_st7;
		@(posedge aclk) disable iff (!aresetn)
		slow_like |-> (st7_tick == lf_tick) && !pre_c;
	endproperty
	a_slow_st7: assert property (p_slow_st7) else $error("stage 7 not on low clock");

	property p_warm_st7;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q == warmup) && from_normal_q |-> (st7_tick == low_c);
	endproperty
	a_warm_st7: assert property (p_warm_st7) else $error("warm-up stage 7 source");

	property p_single_cycle;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q == single_normal) && (mst_q == 2'h0) |-> ##3 (mst_q == 2'h3);
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("cycle not four");

	property p_reset_mode;
		@(posedge aclk) disable iff (!aresetn)
		!$past(aresetn) |-> (mode_q == single_normal) && cpu_run;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("bad reset mode");

	property p_idle_wake;
		@(posedge aclk) disable iff (!aresetn)
		s_idle_wake |=> s_resumed;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle not released");

	property p_idle_halt;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q == single_idle) |-> !cpu_run && !wdt_run && periph_run;
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("idle run outputs");

	property p_tb_latch;
		@(posedge aclk) disable iff (!aresetn)
		tb_exit && tb_armed_q |=> (mode_q == single_normal) && timebase_irq_latch;
	endproperty
	a_tb_latch: assert property (p_tb_latch) else $error("timebase latch missed");

	property p_boundary;
		@(posedge aclk) disable iff (!aresetn)
		(mode_q == dual_normal) && (mode_d != dual_normal) |-> cycle_end;
	endproperty
	a_boundary: assert property (p_boundary) else $error("mode change mid-cycle");
endmodule

// File: verification/scmc_far_model.sv
// Purpose: Far side of the controller: low oscillator and peripheral interrupt.
// Assumes: The bench drives wake as a same-clock level.
// Notes:   The oscillator pin rests low while the oscillator is disabled.
module scmc_far_model (
	// Oscillator
	input  wire logic lf_osc_enable,
	output logic      lowfreq_osc_in,
	// Peripheral side
	input  wire logic wake,
	output logic      periph_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic osc_q = 1'b0;
	initial begin
		forever begin
			#61;
			osc_q = lf_osc_enable ? !osc_q : 1'b0;
		end
	end
	assign lowfreq_osc_in = osc_q;
	assign periph_irq     = wake;
endmodule

// File: verification/scmc_top_tb.sv
// Purpose: Self-checking bench of the clock and mode controller.
// Assumes: Warm-up tap shortened to 8 so stop release stays quick.
// Notes:   Mode progress is followed by polling the status register.
`include "scmc_defs.svh"
module scmc_top_tb import scmc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, stop_release_n = 1'b1, ext_irq = 1'b0;
	logic        wake = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp, resp, machine_state, prev;
	logic [20:0] divider_state, d0;
	logic        awready, wready, bvalid, arready, rvalid, lowfreq_osc_in, periph_irq;
	logic        hf_osc_enable, lf_osc_enable, lf_pins_port, cpu_run, wdt_run, periph_run;
	logic        tbt_run, main_clk_tick, irq_take, resume_next;
	logic        timebase_irq_latch, timebase_irq_take;
	int          n_errors = 0, num_checks = 0, n_take = 0, n_next = 0, n_tbt = 0, t0, n0, sel;

	scmc_top #(.WARM_TAP(8)) scmc_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .lowfreq_osc_in, .stop_release_n,
		.ext_irq, .periph_irq, .hf_osc_enable, .lf_osc_enable, .lf_pins_port, .cpu_run,
		.wdt_run, .periph_run, .tbt_run, .main_clk_tick, .machine_state, .divider_state,
		.irq_take, .resume_next, .timebase_irq_latch, .timebase_irq_take);
	scmc_far_model scmc_far_model_i (.lf_osc_enable, .lowfreq_osc_in, .wake, .periph_irq);

	initial begin
		forever #4 aclk = ~aclk;
	end
	// The bench counts one-cycle pulses; scenarios compare the deltas.
	always @(posedge aclk) begin
		if (irq_take === 1'b1) n_take++;
		if (resume_next === 1'b1) n_next++;
		if (timebase_irq_take === 1'b1) n_tbt++;
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Upper lanes carry random bits that the registers must ignore.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= ($urandom() & 32'hFFFFFF00) | 32'(d);
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_mode(input logic [3:0] m);
		int i;
		i = 0;
		do begin
			rdr(`SCMC_ADDR_STATUS);
			i++;
		end while (rd[3:0] !== m && i < 300);
		chk("mode", rd[3:0], m);
	endtask
	task automatic wait_cpu(input logic v);
		for (int k = 0; k < 20000 && cpu_run !== v; k++) @(posedge aclk);
		chk("cpu_run", cpu_run, v);
	endtask

	initial begin
		void'($urandom(32'hd8aaab32));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk("divider", divider_state, 0);
		chk("lf_pins_port", lf_pins_port, 1);
		chk("cpu_run", cpu_run, 1);
		wait_mode(single_normal);
		prev = machine_state;
		repeat (8) begin
			@(posedge aclk);
			chk("machine_state", machine_state, 2'(prev + 2'h1));
			chk("main_clk_tick", main_clk_tick, 1);
			prev = machine_state;
		end
		rdr(8'h14);
		chk("rresp", resp, `SCMC_RESP_SLVERR);
		chk("rdata", rd, 0);
		wr(`SCMC_ADDR_STATUS, 8'hFF);
		chk("bresp", resp, `SCMC_RESP_SLVERR);
		$display("test reset and bus done");
		for (int i = 0; i < 2; i++) begin
			wr(`SCMC_ADDR_IRQ_CTRL, 8'(i));
			wr(`SCMC_ADDR_CTRL_TWO, 8'h01);
			wait_cpu(0);
			chk("wdt_run", wdt_run, 0);
			chk("periph_run", periph_run, 1);
			wait_mode(single_idle);
			t0 = n_take;
			n0 = n_next;
			if (i == 1) ext_irq <= 1'b1;
			else wake <= 1'b1;
			wait_cpu(1);
			repeat (2) @(posedge aclk);
			ext_irq <= 1'b0;
			wake <= 1'b0;
			chk("irq_take", n_take - t0, i);
			chk("resume_next", n_next - n0, 1 - i);
			wait_mode(single_normal);
		end
		$display("test idle done");
		for (int i = 0; i < 2; i++) begin
			sel = $urandom() % 2;
			wr(`SCMC_ADDR_IRQ_CTRL, 8'h07);
			wr(`SCMC_ADDR_TB_CTRL, 8'((i << 4) | (sel << 1)));
			t0 = n_tbt;
			wr(`SCMC_ADDR_CTRL_TWO, 8'h02);
			wait_cpu(0);
			chk("periph_run", periph_run, 0);
			chk("tbt_run", tbt_run, 1);
			wait_cpu(1);
			repeat (2) @(posedge aclk);
			chk("tb_latch", timebase_irq_latch, i);
			chk("tb_take", n_tbt - t0, i);
			wait_mode(single_normal);
		end
		$display("test timebase idle done");
		wr(`SCMC_ADDR_CTRL_ONE, 8'h80);
		for (int k = 0; k < 200 && hf_osc_enable !== 1'b0; k++) @(posedge aclk);
		repeat (4) @(posedge aclk);
		chk("hf_osc_enable", hf_osc_enable, 0);
		chk("divider", divider_state, 0);
		stop_release_n <= 1'b0;
		wait_cpu(1);
		stop_release_n <= 1'b1;
		wait_mode(single_normal);
		$display("test stop done");
		// Low oscillator started before dual use.
		wr(`SCMC_ADDR_CTRL_TWO, 8'h08);
		wait_mode(dual_normal);
		chk("lf_pins_port", lf_pins_port, 0);
		chk("lf_osc_enable", lf_osc_enable, 1);
		// Stage seven select set only once the low oscillator runs.
		wr(`SCMC_ADDR_TB_CTRL, 8'h01);
		d0 = divider_state;
		repeat (48) @(posedge aclk);
		chk("st7 low feed", (divider_state[20:6] - d0[20:6]) > 15'h0001, 1);
		wr(`SCMC_ADDR_CTRL_TWO, 8'h0C);
		wait_mode(slow_both_osc);
		chk("hf_osc_enable", hf_osc_enable, 1);
		d0 = divider_state;
		repeat (48) @(posedge aclk);
		chk("slow low stages", divider_state[5:0], d0[5:0]);
		chk("slow st7 feed", divider_state[20:6] != d0[20:6], 1);
		wr(`SCMC_ADDR_CTRL_TWO, 8'h08);
		wait_mode(dual_normal);
		// Stage seven select cleared before single-clock mode.
		wr(`SCMC_ADDR_TB_CTRL, 8'h00);
		wr(`SCMC_ADDR_CTRL_TWO, 8'h00);
		wait_mode(single_normal);
		chk("lf_pins_port", lf_pins_port, 1);
		$display("test dual clock done");
		stop_test();
	end
	initial begin
		#400000;
		n_errors++;
		$display("ERROR watchdog expected done seen timeout");
		stop_test();
	end
endmodule
